// ### rtl/oscillator_mode_and_pll_select.sv
// Oscillator mode decode, PLL gating, lock timer and clock source switch
`timescale 1ns/1ns
module oscillator_mode_and_pll_select #(
    parameter int PLL_LOCK_CYCLES = osc_mode_pkg::PLL_LOCK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] osc_mode_field,
    input wire logic clock_switch_enable_n,
    input wire logic auxOscEnable,
    input wire logic aux_timer_oscillator,
    input wire logic osc_in_pin,
    input wire logic selectWrite,
    input wire logic selectWriteData,
    input wire logic port_a_bit_six,
    input wire logic portABitSixOeN,
    output logic osc_out_pin,
    output logic oscOutPinOeN,
    output logic system_clock_select,
    output logic pllEnable,
    output logic [2:0] pllRatio,
    output logic feedbackEnable,
    output logic executionHold
);
    localparam logic [osc_mode_pkg::TIMER_W-1:0] PLL_LOAD =
        osc_mode_pkg::TIMER_W'(PLL_LOCK_CYCLES);

    osc_mode_pkg::state_type s;
    osc_mode_pkg::state_type next_s;
    logic oscRise;
    logic auxRise;
    logic srcRise;
    logic isPll;
    logic isExtClk;
    logic switchAllowed;

    // Sampled clocks only suit sources well below half of sys_clk
    osc_pin_sync oscSync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pinIn(osc_in_pin),
        .level(),
        .rise(oscRise)
    );

    osc_pin_sync auxSync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pinIn(aux_timer_oscillator),
        .level(),
        .rise(auxRise)
    );

    assign isPll = (osc_mode_field == osc_mode_pkg::MODE_HIGH_SPEED_PLL);
    assign isExtClk = (osc_mode_field == osc_mode_pkg::MODE_EXT_CLOCK) ||
        (osc_mode_field == osc_mode_pkg::MODE_EXT_CLOCK_IO);
    assign switchAllowed = !clock_switch_enable_n && auxOscEnable;
    assign srcRise = s.target ? auxRise : oscRise;

    always_comb begin
        next_s = s;
        case (s.fsm)
            osc_mode_pkg::FSM_STARTUP: begin
                // Field only sampled here, so it acts as a strap
                next_s.mode = osc_mode_field;
                next_s.pllOn = isPll;
                next_s.pllRatio = isPll ? osc_mode_pkg::PLL_RATIO_ON :
                    osc_mode_pkg::PLL_RATIO_OFF;
                next_s.hold = 1'b1;
                if (isPll) begin
                    next_s.timer = PLL_LOAD;
                end else if (isExtClk) begin
                    // Budget counts from reset release, state edges included
                    next_s.timer = osc_mode_pkg::EXT_STARTUP_CYCLES;
                end else begin
                    next_s.timer = '0;
                end
                next_s.fsm = osc_mode_pkg::FSM_LOCK;
            end
            osc_mode_pkg::FSM_LOCK: begin
                if (s.timer == '0) begin
                    next_s.hold = 1'b0;
                    next_s.fsm = osc_mode_pkg::FSM_RUN;
                end else begin
                    next_s.timer = s.timer - 1'b1;
                end
            end
            osc_mode_pkg::FSM_RUN: begin
                if (selectWrite && selectWriteData && !s.clkSel) begin
                    if (switchAllowed) begin
                        next_s.target = 1'b1;
                        next_s.edgeCount = '0;
                        next_s.hold = 1'b1;
                        next_s.fsm = osc_mode_pkg::FSM_SWITCH;
                    end else begin
                        next_s.clkSel = 1'b0;
                    end
                end else if (selectWrite && !selectWriteData && s.clkSel) begin
                    next_s.target = 1'b0;
                    next_s.edgeCount = '0;
                    next_s.hold = 1'b1;
                    next_s.fsm = osc_mode_pkg::FSM_SWITCH;
                end
            end
            osc_mode_pkg::FSM_SWITCH: begin
                if (srcRise) begin
                    if (s.edgeCount == osc_mode_pkg::SWITCH_EDGES - 4'h1) begin
                        next_s.clkSel = s.target;
                        if (s.target) begin
                            next_s.hold = 1'b0;
                            next_s.fsm = osc_mode_pkg::FSM_RUN;
                        end else begin
                            // Back on main: PLL may be re-decided
                            next_s.fsm = osc_mode_pkg::FSM_STARTUP;
                        end
                    end else begin
                        next_s.edgeCount = s.edgeCount + 4'h1;
                    end
                end
            end
            default: begin
                next_s.fsm = osc_mode_pkg::FSM_STARTUP;
            end
        endcase

        if (oscRise) begin
            next_s.divCount = ~s.divCount;
            if (s.divCount) begin
                next_s.divOut = ~s.divOut;
            end
        end

        // Pin function and amplifier decode
        case (s.mode)
            osc_mode_pkg::MODE_RES_CAP,
            osc_mode_pkg::MODE_EXT_CLOCK: begin
                next_s.pinOut = s.divOut;
                next_s.pinOeN = 1'b0;
                next_s.feedbackOn = 1'b0;
            end
            osc_mode_pkg::MODE_RES_CAP_IO,
            osc_mode_pkg::MODE_EXT_CLOCK_IO: begin
                next_s.pinOut = port_a_bit_six;
                next_s.pinOeN = portABitSixOeN;
                next_s.feedbackOn = 1'b0;
            end
            default: begin
                // Pin left to crystal in all four crystal modes, PLL mode included
                next_s.pinOut = 1'b0;
                next_s.pinOeN = 1'b1;
                next_s.feedbackOn = 1'b1;
            end
        endcase
        if (s.fsm == osc_mode_pkg::FSM_STARTUP) begin
            next_s.pinOeN = 1'b1;
            next_s.feedbackOn = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.fsm <= osc_mode_pkg::FSM_STARTUP;
            s.pllRatio <= osc_mode_pkg::PLL_RATIO_OFF;
            s.clkSel <= osc_mode_pkg::RESET_SELECT;
            s.hold <= osc_mode_pkg::RESET_HOLD;
            s.pinOeN <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign osc_out_pin = s.pinOut;
    assign oscOutPinOeN = s.pinOeN;
    assign system_clock_select = s.clkSel;
    assign pllEnable = s.pllOn;
    assign pllRatio = s.pllRatio;
    assign feedbackEnable = s.feedbackOn;
    assign executionHold = s.hold;

    pll_mode_only_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        s.pllOn |-> s.mode == osc_mode_pkg::MODE_HIGH_SPEED_PLL)
        else $error("PLL on outside PLL mode");
    mode_static_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        s.fsm == osc_mode_pkg::FSM_RUN |=> $stable(s.mode))
        else $error("Mode changed while running");
    pll_steady_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        s.fsm != osc_mode_pkg::FSM_STARTUP |=> $stable(pllEnable))
        else $error("PLL enable changed in operation");
    lock_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(s.fsm == osc_mode_pkg::FSM_LOCK) && s.pllOn |->
        executionHold [*8])
        else $error("Execution released before PLL lock");
    ratio_four_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        s.fsm == osc_mode_pkg::FSM_RUN |->
        (pllRatio == 3'h4) == pllEnable)
        else $error("PLL ratio wrong");
    ignored_write_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        s.fsm == osc_mode_pkg::FSM_RUN && !s.clkSel && selectWrite &&
        selectWriteData && !switchAllowed |=>
        !system_clock_select && s.fsm == osc_mode_pkg::FSM_RUN)
        else $error("Forbidden select write took effect");
    switch_gate_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(system_clock_select) |->
        !$past(clock_switch_enable_n, 9))
        else $error("Switch without enable");
    eight_edges_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $changed(system_clock_select) |->
        $past(s.edgeCount) == 4'h7 && $past(srcRise))
        else $error("Switch before eight edges");
    ext_feedback_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        s.fsm == osc_mode_pkg::FSM_RUN &&
        (s.mode == osc_mode_pkg::MODE_EXT_CLOCK ||
        s.mode == osc_mode_pkg::MODE_EXT_CLOCK_IO) |-> !feedbackEnable)
        else $error("Feedback on with outside clock");
    ext_startup_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(s.fsm == osc_mode_pkg::FSM_LOCK) && !s.pllOn |->
        ##[1:16] !executionHold)
        else $error("Start-up too long");
    div_out_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        s.fsm == osc_mode_pkg::FSM_RUN &&
        (s.mode == osc_mode_pkg::MODE_RES_CAP ||
        s.mode == osc_mode_pkg::MODE_EXT_CLOCK) |=>
        !oscOutPinOeN && osc_out_pin == $past(s.divOut))
        else $error("Divided clock not on output pin");
    io_pin_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        s.fsm == osc_mode_pkg::FSM_RUN &&
        (s.mode == osc_mode_pkg::MODE_RES_CAP_IO ||
        s.mode == osc_mode_pkg::MODE_EXT_CLOCK_IO) |=>
        osc_out_pin == $past(port_a_bit_six))
        else $error("Output pin not port bit");

    to_aux_c: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(system_clock_select));
    to_main_c: cover property (@(posedge sys_clk) disable iff (rst)
        $fell(system_clock_select));
    pll_lock_c: cover property (@(posedge sys_clk) disable iff (rst)
        pllEnable && $fell(executionHold));
endmodule

// ### rtl/osc_mode_pkg.sv
// Constants and types for oscillator mode and clock source selection
package osc_mode_pkg;
    // Mode codes of the static three-bit configuration field
    localparam logic [2:0] MODE_LOW_POWER = 3'h0;
    localparam logic [2:0] MODE_CRYSTAL = 3'h1;
    localparam logic [2:0] MODE_HIGH_SPEED = 3'h2;
    localparam logic [2:0] MODE_RES_CAP = 3'h3;
    localparam logic [2:0] MODE_EXT_CLOCK = 3'h4;
    localparam logic [2:0] MODE_EXT_CLOCK_IO = 3'h5;
    localparam logic [2:0] MODE_HIGH_SPEED_PLL = 3'h6;
    localparam logic [2:0] MODE_RES_CAP_IO = 3'h7;

    localparam logic [2:0] PLL_RATIO_ON = 3'h4;
    localparam logic [2:0] PLL_RATIO_OFF = 3'h1;
    localparam logic [3:0] SWITCH_EDGES = 4'h8;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int EXT_STARTUP_NS = 1500;
    localparam int PLL_LOCK_US = 2000;
    localparam int TIMER_W = 15;
    // Two state edges after reset eat into the start-up budget
    localparam int STARTUP_STATE_EDGES = 2;
    localparam logic [TIMER_W-1:0] EXT_STARTUP_CYCLES =
        TIMER_W'(EXT_STARTUP_NS / CLK_PERIOD_NS - STARTUP_STATE_EDGES);
    localparam int PLL_LOCK_CYCLES = PLL_LOCK_US * 1000 / CLK_PERIOD_NS;

    // Reset values
    localparam logic RESET_SELECT = 1'b0;
    localparam logic RESET_HOLD = 1'b1;

    typedef enum logic [3:0] {
        FSM_STARTUP = 4'h1,
        FSM_RUN = 4'h2,
        FSM_SWITCH = 4'h4,
        FSM_LOCK = 4'h8
    } fsm_type;

    typedef struct packed {
        logic stage1;
        logic stage2;
        logic prev;
    } sync_type;

    typedef struct packed {
        fsm_type fsm;
        logic [2:0] mode;
        logic pllOn;
        logic [2:0] pllRatio;
        logic clkSel;
        logic target;
        logic [3:0] edgeCount;
        logic [TIMER_W-1:0] timer;
        logic hold;
        logic divCount;
        logic divOut;
        logic pinOut;
        logic pinOeN;
        logic feedbackOn;
    } state_type;
endpackage

// ### rtl/osc_pin_sync.sv
// Two-stage synchroniser with rising-edge detect for a pin or foreign clock
`timescale 1ns/1ns
module osc_pin_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pinIn,
    output logic level,
    output logic rise
);
    osc_mode_pkg::sync_type s;
    osc_mode_pkg::sync_type next_s;

    always_comb begin
        next_s = s;
        next_s.stage1 = pinIn;
        next_s.stage2 = s.stage1;
        next_s.prev = s.stage2;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.stage2;
    assign rise = s.stage2 & ~s.prev;
endmodule

// ### sim/osc_source_model.sv
// Behavioural main and auxiliary clock sources at the oscillator pins
`timescale 1ns/1ns
module osc_source_model #(
    parameter int MAIN_HALF_NS = 600,
    parameter int AUX_HALF_NS = 800
) (
    input wire logic auxRun,
    output logic mainClk,
    output logic auxClk
);
    // External clock driven into the input pin in every mode
    initial begin
        mainClk = 1'b0;
        forever #(MAIN_HALF_NS) mainClk = ~mainClk;
    end

    // Aux source stands low while disabled, so no stray edges count
    initial begin
        auxClk = 1'b0;
        forever begin
            #(AUX_HALF_NS);
            auxClk = auxRun ? ~auxClk : 1'b0;
        end
    end
endmodule

// ### sim/test_oscillator_mode_and_pll_select.sv
// Directed bench for oscillator mode decode, lock timing and clock switch
`timescale 1ns/1ns
`define CHK(got, exp, msg) \
    num_checks++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("BAD at %0t: %s", $time, msg); \
    end
module test_oscillator_mode_and_pll_select;
    localparam int LOCK = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] mode = osc_mode_pkg::MODE_LOW_POWER;
    logic switchEnN = 1'b1;
    logic auxOn = 1'b0;
    logic auxClk, mainClk;
    logic selWr = 1'b0;
    logic selData = 1'b0;
    logic portBit = 1'b0;
    logic portOeN = 1'b1;
    logic outPin, outOeN, clkSel, pllEn, feedback, hold;
    logic [2:0] ratio;
    int n_mismatch = 0;
    int num_checks = 0;
    int inRise = 0;
    int auxRise = 0;

    always #50 sys_clk = ~sys_clk;
    always @(posedge mainClk) inRise++;
    always @(posedge auxClk) auxRise++;

    osc_source_model osc_source_model_i (.auxRun(auxOn), .mainClk(mainClk),
        .auxClk(auxClk));

    oscillator_mode_and_pll_select #(.PLL_LOCK_CYCLES(LOCK))
        oscillator_mode_and_pll_select_i (
        .sys_clk(sys_clk), .rst(rst), .osc_mode_field(mode),
        .clock_switch_enable_n(switchEnN), .auxOscEnable(auxOn),
        .aux_timer_oscillator(auxClk), .osc_in_pin(mainClk),
        .selectWrite(selWr), .selectWriteData(selData),
        .port_a_bit_six(portBit), .portABitSixOeN(portOeN),
        .osc_out_pin(outPin), .oscOutPinOeN(outOeN),
        .system_clock_select(clkSel), .pllEnable(pllEn), .pllRatio(ratio),
        .feedbackEnable(feedback), .executionHold(hold));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Edges counted from the first clock after the call, which after reset is the edge into lock
    task automatic wait_hold_low(input int maxCyc, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (hold !== 1'b0 && n < maxCyc);
    endtask

    task automatic write_select(input logic d);
        @(posedge sys_clk);
        selWr <= 1'b1;
        selData <= d;
        @(posedge sys_clk);
        selWr <= 1'b0;
    endtask

    // Mode strap changes only under reset, as a programmed field would
    task automatic run_mode(input logic [2:0] m);
        int n, c0, expT;
        logic isPll, isXtal, isClkOut, isIo;
        isPll = (m === osc_mode_pkg::MODE_HIGH_SPEED_PLL);
        isXtal = isPll || m === osc_mode_pkg::MODE_LOW_POWER ||
            m === osc_mode_pkg::MODE_CRYSTAL ||
            m === osc_mode_pkg::MODE_HIGH_SPEED;
        isClkOut = (m === osc_mode_pkg::MODE_RES_CAP ||
            m === osc_mode_pkg::MODE_EXT_CLOCK);
        isIo = (m === osc_mode_pkg::MODE_RES_CAP_IO ||
            m === osc_mode_pkg::MODE_EXT_CLOCK_IO);
        // Edges from release to run: two state edges, lock run, or budget
        expT = isPll ? LOCK + 2 : (m === osc_mode_pkg::MODE_EXT_CLOCK ||
            m === osc_mode_pkg::MODE_EXT_CLOCK_IO) ?
            osc_mode_pkg::EXT_STARTUP_NS / osc_mode_pkg::CLK_PERIOD_NS : 2;
        @(posedge sys_clk);
        rst <= 1'b1;
        mode <= m;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        wait_hold_low(200, n);
        `CHK(n, expT, "hold release time")
        `CHK(pllEn, isPll, "pll enable")
        `CHK(ratio, isPll ? osc_mode_pkg::PLL_RATIO_ON :
            osc_mode_pkg::PLL_RATIO_OFF, "pll ratio")
        `CHK(feedback, isXtal, "feedback amp")
        `CHK(clkSel, 1'b0, "select after reset")
        if (isXtal) begin
            `CHK(outOeN, 1'b1, "pin released")
        end
        if (isClkOut) begin
            @(posedge outPin);
            c0 = inRise;
            @(posedge outPin);
            `CHK(inRise - c0, 4, "pin clock ratio")
            `CHK(outOeN, 1'b0, "pin driven")
        end
        if (isIo) begin
            for (int v = 0; v < 2; v++) begin
                @(posedge sys_clk);
                portBit <= v[0];
                portOeN <= ~v[0];
                repeat (3) @(posedge sys_clk);
                `CHK(outPin, v[0], "port data")
                `CHK(outOeN, ~v[0], "port enable")
            end
        end
        $display("end of test mode %0d", m);
    endtask

    task automatic switch_test();
        int a0, n;
        run_mode(osc_mode_pkg::MODE_HIGH_SPEED_PLL);
        write_select(1'b1);
        repeat (30) @(posedge sys_clk);
        `CHK(clkSel, 1'b0, "switch bit disabled")
        @(posedge sys_clk);
        switchEnN <= 1'b0;
        write_select(1'b1);
        repeat (30) @(posedge sys_clk);
        `CHK(clkSel, 1'b0, "aux oscillator off")
        `CHK(hold, 1'b0, "refused write no hold")
        @(posedge sys_clk);
        auxOn <= 1'b1;
        repeat (40) @(posedge sys_clk);
        a0 = auxRise;
        write_select(1'b1);
        #1 `CHK(hold, 1'b1, "frozen during switch")
        wait_hold_low(400, n);
        `CHK(clkSel, 1'b1, "aux selected")
        `CHK(auxRise - a0 >= 8, 1'b1, "eight aux edges")
        `CHK(pllEn, 1'b1, "pll steady in run")
        a0 = inRise;
        write_select(1'b0);
        wait_hold_low(400, n);
        `CHK(clkSel, 1'b0, "main selected")
        `CHK(inRise - a0 >= 8, 1'b1, "eight main edges")
        `CHK(pllEn, 1'b1, "pll after return")
        `CHK(ratio, osc_mode_pkg::PLL_RATIO_ON, "ratio return")
        $display("end of test clock switch");
    endtask

    initial begin
        for (int m = 0; m < 8; m++)
            run_mode(m[2:0]);
        switch_test();
        wrap_up();
    end

    initial begin
        #(20000 * 100);
        n_mismatch++;
        $display("BAD at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
